// file: hdl/rco_top.sv
// reference clock output divider with an AHB-Lite register slave
//
// Contract
// [RULE1] the system clock is the only source; a divided copy drives the pin
// [RULE2] control bit 7 enables the block; clear disables it
// [RULE3] control bit 6 puts the divided clock on the pin
// [RULE4] control bits 2-0 pick one of eight division ratios
// [RULE5] divider code 111 divides the base clock by 128
// [RULE6] bits 4-3 set duty: 11 is 75%, 00 holds output low
// [RULE7] undivided clock keeps source duty; only 0% still forces low
// [RULE8] divide-by-two 25/75% accuracy depends on source waveform; here 25% holds the pin low and 75% gives 50%
// [RULE9] control bit 5 enables slew limiting on the pin
// [RULE10] any reset disables the block and restores the control defaults
// [RULE11] software programs divider, duty and slew before enabling output
// [RULE12] in sleep no edges are made and outputs hold their level; refclk_slew_limit still follows control bit 5 in sleep
// [RULE13] duty code 10 is 50%, 01 is 25%; 10 is the default
// [RULE14] codes 110..001 divide by 64,32,16,8,4,2; 000 passes undivided
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module rco_top
  import rco_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic sleep_req,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic refclk_output_pin,
  output logic refclk_pin_oe,
  output logic refclk_slew_limit
);

`include "rco_defs.svh"

  rco_cfg_if cfg ();

  logic [7:0] refclk_control_reg_r;
  logic [7:0] refclk_control_reg_nxt;
  logic sleep_r;
  logic sleep_nxt;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic pin_r;
  logic oe_r;
  logic slr_r;
  logic base_r;
  logic base_nxt;
  rco_state_t state_r;
  rco_state_t state_nxt;

  wire refclk_module_enable = refclk_control_reg_r[`RCO_BIT_EN];
  wire refclk_pin_output_enable = refclk_control_reg_r[`RCO_BIT_OE];
  wire refclk_slew_limit_enable = refclk_control_reg_r[`RCO_BIT_SLR];
  wire [1:0] refclk_duty_select = refclk_control_reg_r[`RCO_DC_HI:`RCO_DC_LO];
  wire [2:0] refclk_divider_select = refclk_control_reg_r[`RCO_DIV_HI:`RCO_DIV_LO];

  // address-phase decode; NONSEQ and SEQ transfers are taken, hsize is not checked
  wire trans_ok = hsel && hready &&
    ((htrans == `RCO_HTRANS_NONSEQ) || (htrans == `RCO_HTRANS_SEQ));
  wire wr_take = trans_ok && hwrite;
  wire rd_take = trans_ok && !hwrite;

  wire wr_ctrl = wr_pend_r && (wr_addr_r == `RCO_CTRL_OFFSET);
  wire wr_sleep = wr_pend_r && (wr_addr_r == `RCO_SLEEP_OFFSET);

  assign refclk_control_reg_nxt = wr_ctrl ? hwdata[7:0] : refclk_control_reg_r;
  assign sleep_nxt = sleep_req | (wr_sleep ? hwdata[0] : sleep_r);

  // read data captured in the address phase; unmapped words read zero
  wire [31:0] rd_value =
    (haddr == `RCO_CTRL_OFFSET) ? {24'h000000, refclk_control_reg_r} :
    (haddr == `RCO_SLEEP_OFFSET) ? {31'h00000000, sleep_r} :
    (haddr == `RCO_STATUS_OFFSET) ?
      {16'h0000, 6'h00, state_r, 1'b0, cfg.count} :
    32'h00000000;
  assign hrdata_nxt = rd_take ? rd_value : hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      wr_pend_r <= wr_take;
      wr_addr_r <= wr_take ? haddr : wr_addr_r;
      hrdata_r <= hrdata_nxt;
    end
  end

  // every reset restores defaults, which leave the block disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refclk_control_reg_r <= `RCO_CTRL_RESET; // [RULE10]
      sleep_r <= 1'b0;
    end else begin
      refclk_control_reg_r <= refclk_control_reg_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  // gray path off -> run -> hold
  always_comb begin
    case (state_r)
      RCO_ST_OFF: state_nxt = refclk_module_enable ? RCO_ST_RUN : RCO_ST_OFF; // [RULE2]
      RCO_ST_RUN: state_nxt = !refclk_module_enable ? RCO_ST_OFF :
                              sleep_r ? RCO_ST_HOLD : RCO_ST_RUN;
      RCO_ST_HOLD: state_nxt = sleep_r ? RCO_ST_HOLD :
                               refclk_module_enable ? RCO_ST_RUN : RCO_ST_OFF; // [RULE12]
      default: state_nxt = RCO_ST_OFF;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= RCO_ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign cfg.run = (state_r != RCO_ST_OFF);
  assign cfg.hold = (state_r == RCO_ST_HOLD);
  assign cfg.div_sel = refclk_divider_select;
  assign cfg.duty_sel = rco_duty_t'(refclk_duty_select);

  rco_divider_core u_core (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(cfg)
  );

  // software should set divider, duty and slew before enabling [RULE11]
  // pin held low while the output enable is clear; level frozen in sleep
  wire pin_nxt = cfg.hold ? pin_r :
                 (refclk_pin_output_enable ? cfg.clk_out : 1'b0); // [RULE3]

  // undivided mode: the gate opens only while running, enabled and not at 0%
  assign base_nxt = !cfg.hold && (refclk_divider_select == 3'h0) && pin_nxt; // [RULE7]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_r <= 1'b0;
      oe_r <= 1'b0;
      slr_r <= 1'b1;
      base_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt; // [RULE1]
      base_r <= base_nxt; // [RULE7]
      oe_r <= cfg.hold ? oe_r : refclk_pin_output_enable; // [RULE3]
      slr_r <= refclk_slew_limit_enable; // [RULE9]
    end
  end

  // a register cannot carry the undivided clock, so only that mode is gated;
  // the gate moves at a rising edge, so leaving the mode may clip one high phase
  assign refclk_output_pin = base_r ? hclk : pin_r; // [RULE7]
  assign refclk_pin_oe = oe_r;
  assign refclk_slew_limit = slr_r;
  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule

`default_nettype wire

// file: hdl/rco_defs.svh
// register offsets, field positions, reset value and bus codes for the reference clock divider
`ifndef RCO_DEFS_SVH
`define RCO_DEFS_SVH

`define RCO_CTRL_OFFSET 8'h00
`define RCO_SLEEP_OFFSET 8'h04
`define RCO_STATUS_OFFSET 8'h08

`define RCO_BIT_EN 7
`define RCO_BIT_OE 6
`define RCO_BIT_SLR 5
`define RCO_DC_HI 4
`define RCO_DC_LO 3
`define RCO_DIV_HI 2
`define RCO_DIV_LO 0

`define RCO_CTRL_RESET 8'h30

`define RCO_HTRANS_NONSEQ 2'h2
`define RCO_HTRANS_SEQ 2'h3
`define RCO_HSIZE_WORD 3'h2

`endif

// file: hdl/rco_pkg.sv
// types shared by the reference clock divider modules
package rco_pkg;

  typedef enum logic [1:0] {
    RCO_DC_0 = 2'h0,
    RCO_DC_25 = 2'h1,
    RCO_DC_50 = 2'h2,
    RCO_DC_75 = 2'h3
  } rco_duty_t;

  typedef enum logic [1:0] {
    RCO_ST_OFF = 2'h0,
    RCO_ST_RUN = 2'h1,
    RCO_ST_HOLD = 2'h3
  } rco_state_t;

  typedef logic [2:0] rco_div_t;

endpackage

// file: hdl/rco_cfg_if.sv
// configuration bundle between the bus side and the divider core
`timescale 1ns/1ps
`default_nettype none

interface rco_cfg_if;
  import rco_pkg::*;
  logic run;
  logic hold;
  rco_div_t div_sel;
  rco_duty_t duty_sel;
  logic clk_out;
  logic [6:0] count;

  modport ctrl (output run, output hold, output div_sel, output duty_sel,
    input clk_out, input count);
  modport core (input run, input hold, input div_sel, input duty_sel,
    output clk_out, output count);
endinterface

`default_nettype wire

// file: hdl/rco_divider_core.sv
// free counter and waveform shaper producing the divided reference clock
`timescale 1ns/1ps
`default_nettype none

module rco_divider_core
  import rco_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  rco_cfg_if.core cfg
);

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic wave_r;
  logic wave_nxt;
  logic [6:0] period_m1;
  logic [7:0] threshold;
  logic wave_div;

  // ratio 2^code; code 000 is the undivided base clock
  function automatic logic [6:0] rco_mask(input rco_div_t code);
    rco_mask = 7'(8'h7F >> (3'h7 - code));
  endfunction

  // high-time threshold in counts for a period of (mask + 1)
  function automatic logic [7:0] rco_high(input rco_div_t code, input rco_duty_t dc);
    logic [7:0] per;
    per = 8'({1'b0, rco_mask(code)}) + 8'h01;
    case (dc)
      RCO_DC_25: rco_high = per >> 2;
      RCO_DC_50: rco_high = per >> 1;
      RCO_DC_75: rco_high = (per >> 1) + (per >> 2);
      default: rco_high = 8'h00;
    endcase
  endfunction

  assign period_m1 = rco_mask(cfg.div_sel); // [RULE4] [RULE5] [RULE14]
  assign threshold = rco_high(cfg.div_sel, cfg.duty_sel); // [RULE6] [RULE13]
  // divide-by-2 quarters fall between source rising edges: 25% rounds to 0% (low) and 75% to 50% [RULE8]
  // undivided: the wave is only the gate that lets the system clock reach the pin
  assign wave_div = (cfg.div_sel == 3'h0) ? (cfg.duty_sel != RCO_DC_0) :
                    ({1'b0, cnt_r} < threshold);

  // frozen while sleeping, cleared when disabled [RULE12] [RULE2]
  assign cnt_nxt = !cfg.run ? 7'h00 :
                   cfg.hold ? cnt_r :
                   (cnt_r >= period_m1) ? 7'h00 : 7'(cnt_r + 7'h01);

  assign wave_nxt = !cfg.run ? 1'b0 :
                    cfg.hold ? wave_r :
                    wave_div;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 7'h00;
      wave_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt; // [RULE1]
      wave_r <= wave_nxt;
    end
  end

  // registered wave only; the clock itself is never sampled as data [RULE7]
  assign cfg.clk_out = wave_r;
  assign cfg.count = cnt_r;

endmodule

`default_nettype wire

// file: testbench/rco_props.sv
// port-level assertion checker for the reference clock divider
`timescale 1ns/1ps
`default_nettype none
module rco_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic sleep_req,
  input wire logic [31:0] hrdata,
  input wire logic refclk_output_pin,
  input wire logic refclk_pin_oe,
  input wire logic refclk_slew_limit
);
  logic [7:0] ctl_r, a_r;
  logic wr_r, rd_r, slp_r;
  logic [3:0] age_r;
  wire take = hsel && hready && htrans[1];
  // settle margin after any control or sleep change
  wire quiet = age_r > 4'h4;
  wire run = quiet && !slp_r && ctl_r[7];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_r <= 8'h30;
      slp_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      a_r <= 8'h00;
      age_r <= 4'h0;
    end else begin
      wr_r <= take && hwrite;
      rd_r <= take && !hwrite;
      a_r <= haddr;
      if (wr_r && a_r == 8'h00) ctl_r <= hwdata[7:0];
      slp_r <= sleep_req || (wr_r && a_r == 8'h04 ? hwdata[0] : slp_r);
      age_r <= (wr_r || sleep_req) ? 4'h0 : age_r + {3'h0, !age_r[3]};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rst; $rose(hresetn) |-> !refclk_pin_oe && !refclk_output_pin && refclk_slew_limit;
  endproperty
  property p_oe; quiet |-> refclk_pin_oe == ctl_r[6]; endproperty
  property p_slr; quiet |-> refclk_slew_limit == ctl_r[5]; endproperty
  property p_off; quiet && !ctl_r[7] |-> !refclk_output_pin; endproperty
  property p_zero; quiet && !slp_r && ctl_r[4:3] == 2'h0 |-> !refclk_output_pin; endproperty
  property p_hold; quiet && slp_r |=> $stable(refclk_output_pin); endproperty
  property p_div2; run && ctl_r[4:0] == 5'h11 |=> refclk_output_pin != $past(refclk_output_pin);
  endproperty
  property p_rd; rd_r && a_r == 8'h00 |-> hrdata == {24'h0, ctl_r}; endproperty
  a_rst: assert property (p_rst) else $error("outputs not at defaults after reset");
  a_oe: assert property (p_oe) else $error("pin enable differs from control");
  a_slr: assert property (p_slr) else $error("slew limit differs from control");
  a_off: assert property (p_off) else $error("pin active while disabled");
  a_zero: assert property (p_zero) else $error("zero duty pin not low");
  a_hold: assert property (p_hold) else $error("pin moved in sleep");
  a_div2: assert property (p_div2) else $error("divide by two not toggling");
  a_rd: assert property (p_rd) else $error("control readback wrong");
  c_run: cover property (run && refclk_output_pin);
  c_slp: cover property (quiet && slp_r);
  c_rst: cover property ($rose(hresetn));
endmodule
bind rco_top rco_props rco_props_inst (.*);
`default_nettype wire

// file: testbench/rco_ext_dev.sv
// external device clocked from the reference clock pin
`timescale 1ns/1ps
`default_nettype none
module rco_ext_dev (
  input wire logic refclk_output_pin,
  input wire logic refclk_pin_oe,
  output var int edges
);
  initial edges = 0;
  always @(posedge refclk_output_pin) if (refclk_pin_oe) edges++;
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the reference clock divider
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sleep_req = 0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic hreadyout, hresp, pin, oe, slr;
  int fails = 0, cmp_count = 0, hi, e0, e1;
  always #5 hclk = ~hclk;
  rco_top rco_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .sleep_req(sleep_req), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .refclk_output_pin(pin), .refclk_pin_oe(oe), .refclk_slew_limit(slr));
  rco_ext_dev rco_ext_dev_inst (.refclk_output_pin(pin), .refclk_pin_oe(oe), .edges(e0));
  task chk(string n, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("Error %s exp %h got %h", n, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task xfer(logic w, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hsize <= 3'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // high cycles of the pin over n cycles
  task meas(int n, int e);
    hi = 0;
    repeat (n + 4) @(negedge hclk);
    repeat (n) begin
      @(negedge hclk);
      hi += (pin === 1'b1);
    end
    chk("high", e, hi);
    @(posedge hclk);
  endtask
  task idle_edges(logic [31:0] grow);
    // the pin may still move for a few edges after the control change
    repeat (4) @(posedge hclk);
    e1 = e0;
    repeat (40) @(posedge hclk);
    chk("edges", grow, e0 > e1);
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(0, 8'h00, 0); chk("ctl", 32'h30, q);
    chk("oe", 0, oe); chk("slew", 1, slr);
    xfer(0, 8'h0C, 0); chk("unmapped", 0, q);
    for (int c = 1; c < 8; c++) begin
      // settings go in before the enable
      xfer(1, 8'h00, 32'h50 | c);
      xfer(1, 8'h00, 32'hD0 | c);
      meas(2 << c, 1 << c);
    end
    chk("oe", 1, oe); chk("slew", 0, slr);
    for (int d = 0; d < 4; d++) begin
      xfer(1, 8'h00, 32'hC3 | d << 3);
      meas(8, 2 * d);
    end
    xfer(1, 8'h00, 32'hC0); meas(16, 0);
    xfer(1, 8'h00, 32'hD0);
    repeat (4) @(posedge hclk);
    e1 = e0;
    repeat (40) @(posedge hclk);
    chk("base edges", 1, (e0 - e1 > 38) && (e0 - e1 < 42));
    #2 chk("base high", 1, pin);
    @(negedge hclk) chk("base low", 0, pin);
    xfer(1, 8'h00, 32'hD2); idle_edges(1);
    xfer(1, 8'h04, 1); idle_edges(0);
    xfer(1, 8'h04, 0); idle_edges(1);
    sleep_req <= 1'b1;
    @(posedge hclk);
    sleep_req <= 1'b0;
    // the hold state is entered one edge after the sleep flag is set
    @(posedge hclk);
    xfer(0, 8'h08, 0); chk("state", 3, q[9:8]);
    xfer(1, 8'h04, 0);
    xfer(1, 8'h00, 32'h52); idle_edges(0);
    xfer(1, 8'h00, 32'hD2);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(0, 8'h00, 0); chk("ctl", 32'h30, q);
    chk("oe", 0, oe); chk("pin", 0, pin);
    stop_test;
  end
  initial begin
    #200us;
    fails++;
    stop_test;
  end
endmodule
`default_nettype wire
